// [rtl/rwt_consts.svh]
// constants of the remote word transfer engine
`ifndef RWT_CONSTS_SVH
`define RWT_CONSTS_SVH
// command codes and block layout
`define RWT_CODE_FETCH 16'h0202
`define RWT_CODE_XCHG 16'h0203
`define RWT_BLK_WORDS 5'h10
`define RWT_OFF_ERR 4'h0
`define RWT_OFF_CODE 4'h1
`define RWT_OFF_CHAN 4'h2
`define RWT_OFF_SRC 4'h3
`define RWT_OFF_CNT 4'h4
`define RWT_OFF_DST 4'h5
`define RWT_OFF_TMO 4'h6
`define RWT_OFF_RSRC 4'h7
`define RWT_OFF_RCNT 4'h8
`define RWT_OFF_RDST 4'h9
`define RWT_OFF_IPHI 4'ha
`define RWT_OFF_IPLO 4'hb
`define RWT_OFF_PORT 4'hc
// field limits
`define RWT_CHAN_LO 16'h4b15
`define RWT_CHAN_HI 16'h4b1c
`define RWT_MAX_FETCH 16'h0100
`define RWT_MAX_WR 16'h00fe
`define RWT_MAX_RD 16'h0100
`define RWT_IP_MAX 32'hdfffffff
`define RWT_TMO_DEFAULT_S 16'h0009
`define RWT_TMO_NEVER 16'h03e7
`define RWT_HDR_LAST 9'h009
// timing
`define RWT_CLK_PERIOD_NS 100
`define RWT_SECOND_NS 1000000000
// error codes written to word 0
`define RWT_ERR_CMD 16'h0001
`define RWT_ERR_CHAN 16'h0002
`define RWT_ERR_COUNT 16'h0003
`define RWT_ERR_IP 16'h0004
`define RWT_ERR_TIMEOUT 16'h0005
`define RWT_ERR_RESP 16'h0006
`define RWT_ERR_WRITE 16'h0007
`define RWT_ERR_READ 16'h0008
// response status words from the peer
`define RWT_RSP_OK 16'h0000
`define RWT_RSP_WFAIL 16'h0001
`define RWT_RSP_RFAIL 16'h0002
// register byte offsets and fields
`define RWT_REG_CTRL 8'h00
`define RWT_REG_STATUS 8'h04
`define RWT_REG_CHAN_BASE 2'b01
`define RWT_CTRL_START 0
`define RWT_ST_BUSY 0
`define RWT_ST_ERR 1
`define RWT_ST_DONE 2
`define RWT_CH_OPEN 0
`define RWT_CH_UDP 1
`define RWT_CH_OVR 2
`endif

// [rtl/rwt_pkg.sv]
// types of the remote word transfer engine
package rwt_pkg;
  typedef enum logic [3:0] {
    S_IDLE = 4'h0,
    S_FETCH = 4'h1,
    S_CHECK = 4'h2,
    S_TXHDR = 4'h3,
    S_TXRD = 4'h4,
    S_TXDAT = 4'h5,
    S_RX = 4'h6,
    S_WB = 4'h7,
    S_ERRW = 4'h8,
    S_FIN = 4'h9
  } rwt_state_e;

  typedef struct packed {
    rwt_state_e st;
    logic [8:0] idx;
    logic [15:0] base;
    logic [15:0][15:0] blk;
    logic xchg;
    logic [31:0] ip;
    logic [15:0] port;
    logic tmo_inf;
    logic [15:0] tmo_sec;
    logic [23:0] tick;
    logic [15:0] rx_status;
    logic [15:0] err_code;
    logic err_flag;
    logic done;
    logic busy;
    logic [7:0][2:0] ch_flags;
    logic [7:0][15:0] ch_port;
    logic [7:0][31:0] ch_ip;
    logic wb_ack;
    logic [31:0] wb_dat;
    logic mem_req;
    logic mem_we;
    logic [15:0] mem_addr;
    logic [15:0] mem_wdata;
    logic tx_valid;
    logic [15:0] tx_data;
    logic tx_last;
  } rwt_state_s;
endpackage

// [rtl/rwt_engine.sv]
// remote word transfer engine: fetch and exchange command interpreter
//
// The Wishbone slave port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`include "rwt_consts.svh"

module rwt_engine
  import rwt_pkg::*;
#(
  parameter int CYC_PER_SEC = `RWT_SECOND_NS / `RWT_CLK_PERIOD_NS
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic mem_req,
  output logic mem_we,
  output logic [15:0] mem_addr,
  output logic [15:0] mem_wdata,
  input wire logic [15:0] mem_rdata,
  input wire logic mem_ack,
  output logic tx_valid,
  output logic [15:0] tx_data,
  output logic tx_last,
  input wire logic tx_ready,
  input wire logic rx_valid,
  input wire logic [15:0] rx_data,
  input wire logic rx_last,
  output logic busy,
  output logic cmd_error_flag
);

  rwt_state_s state_reg;
  rwt_state_s state_next;
  // reply words are parked here until the whole reply is verified
  logic [15:0] rxbuf [0:255];
  logic [15:0] rxbuf_q;
  logic [2:0] ch;
  logic [2:0] wch;
  logic ovr;
  logic [31:0] blk_ip;
  logic [15:0] rd_cnt;
  logic [15:0] stat;
  logic [15:0] err;
  logic [31:0] cur;

  // byte-lane merge of a wishbone write
  function automatic logic [31:0] merge(input logic [31:0] o,
                                        input logic [31:0] d,
                                        input logic [3:0] s);
    logic [31:0] m;
    m = o;
    for (int b = 0; b < 4; b++) begin
      if (s[b]) begin
        m[b*8 +: 8] = d[b*8 +: 8];
      end
    end
    return m;
  endfunction

  // one-based field plus word index to zero-based address
  function automatic logic [15:0] waddr(input logic [15:0] f,
                                        input logic [8:0] i);
    return 16'(f - 16'h0001 + {7'h00, i});
  endfunction

  assign rxbuf_q = rxbuf[state_reg.idx[7:0]];
  assign ch = 3'(state_reg.blk[`RWT_OFF_CHAN] - `RWT_CHAN_LO);
  assign wch = wb_adr_i[5:3];
  assign ovr = state_reg.ch_flags[ch][`RWT_CH_UDP] &
               state_reg.ch_flags[ch][`RWT_CH_OVR];
  assign blk_ip = {state_reg.blk[`RWT_OFF_IPHI],
                   state_reg.blk[`RWT_OFF_IPLO]};
  assign rd_cnt = state_reg.xchg ? state_reg.blk[`RWT_OFF_RCNT] :
                  state_reg.blk[`RWT_OFF_CNT];
  assign stat = (state_reg.idx == 9'h000) ? rx_data :
                state_reg.rx_status;

  // register file and command sequencer
  always_comb begin
    state_next = state_reg;
    state_next.wb_ack = 1'b0;
    err = 16'h0000;
    cur = 32'h0000_0000;
    // wishbone slave, one wait state, unmapped reads return zero
    if (wb_cyc_i && wb_stb_i && !state_reg.wb_ack) begin
      state_next.wb_ack = 1'b1;
      if (wb_adr_i == `RWT_REG_CTRL) begin
        cur = {state_reg.base, 16'h0000};
      end else if (wb_adr_i == `RWT_REG_STATUS) begin
        cur = {state_reg.err_code, 13'h0000, state_reg.done,
               state_reg.err_flag, state_reg.busy};
      end else if (wb_adr_i[7:6] == `RWT_REG_CHAN_BASE) begin
        cur = wb_adr_i[2] ? state_reg.ch_ip[wch] :
              {state_reg.ch_port[wch], 13'h0000,
               state_reg.ch_flags[wch]};
      end
      state_next.wb_dat = cur;
      if (wb_we_i) begin
        cur = merge(cur, wb_dat_i, wb_sel_i);
        if (wb_adr_i == `RWT_REG_CTRL) begin
          state_next.base = cur[31:16];
          // a start while busy is dropped
          if (cur[`RWT_CTRL_START] && !state_reg.busy) begin
            state_next.busy = 1'b1;
            state_next.idx = 9'h000;
            state_next.st = S_FETCH;
          end
        end else if (wb_adr_i == `RWT_REG_STATUS) begin
          // write one to clear; hardware sets below win
          if (cur[`RWT_ST_ERR]) begin
            state_next.err_flag = 1'b0;
          end
          if (cur[`RWT_ST_DONE]) begin
            state_next.done = 1'b0;
          end
        end else if (wb_adr_i[7:6] == `RWT_REG_CHAN_BASE) begin
          if (wb_adr_i[2]) begin
            state_next.ch_ip[wch] = cur;
          end else begin
            state_next.ch_port[wch] = cur[31:16];
            state_next.ch_flags[wch] = cur[2:0];
          end
        end
      end
    end

    unique case (state_reg.st)
      S_IDLE: begin
      end
      // read the sixteen block words one by one
      S_FETCH: begin
        if (!state_reg.mem_req) begin
          state_next.mem_req = 1'b1;
          state_next.mem_we = 1'b0;
          state_next.mem_addr = 16'(state_reg.base +
                                    {7'h00, state_reg.idx});
        end else if (mem_ack) begin
          state_next.mem_req = 1'b0;
          state_next.blk[state_reg.idx[3:0]] = mem_rdata;
          if (state_reg.idx[3:0] == 4'hf) begin
            state_next.idx = 9'h000;
            state_next.st = S_CHECK;
          end else begin
            state_next.idx = 9'(state_reg.idx + 9'h001);
          end
        end
      end
      // field checks, first failing check names the error
      S_CHECK: begin
        state_next.xchg = state_reg.blk[`RWT_OFF_CODE] ==
                          `RWT_CODE_XCHG;
        if (state_reg.blk[`RWT_OFF_CODE] != `RWT_CODE_FETCH &&
            state_reg.blk[`RWT_OFF_CODE] != `RWT_CODE_XCHG) begin
          err = `RWT_ERR_CMD;
        end else if (state_reg.blk[`RWT_OFF_CHAN] < `RWT_CHAN_LO ||
                     state_reg.blk[`RWT_OFF_CHAN] > `RWT_CHAN_HI ||
                     !state_reg.ch_flags[ch][`RWT_CH_OPEN]) begin
          err = `RWT_ERR_CHAN;
        end else if (state_reg.blk[`RWT_OFF_CODE] == `RWT_CODE_FETCH &&
                     (state_reg.blk[`RWT_OFF_CNT] == 16'h0000 ||
                      state_reg.blk[`RWT_OFF_CNT] > `RWT_MAX_FETCH)) begin
          err = `RWT_ERR_COUNT;
        end else if (state_reg.blk[`RWT_OFF_CODE] == `RWT_CODE_XCHG &&
                     (state_reg.blk[`RWT_OFF_CNT] == 16'h0000 ||
                      state_reg.blk[`RWT_OFF_CNT] > `RWT_MAX_WR ||
                      state_reg.blk[`RWT_OFF_RCNT] == 16'h0000 ||
                      state_reg.blk[`RWT_OFF_RCNT] > `RWT_MAX_RD)) begin
          err = `RWT_ERR_COUNT;
        end else if (ovr && (blk_ip == 32'h0000_0000 ||
                             blk_ip > `RWT_IP_MAX)) begin
          err = `RWT_ERR_IP;
        end
        // target comes from the block only under override
        state_next.ip = ovr ? blk_ip : state_reg.ch_ip[ch];
        state_next.port = ovr ? state_reg.blk[`RWT_OFF_PORT] :
                          state_reg.ch_port[ch];
        state_next.tmo_inf = state_reg.blk[`RWT_OFF_TMO] ==
                             `RWT_TMO_NEVER;
        state_next.tmo_sec = (state_reg.blk[`RWT_OFF_TMO] == 16'h0000) ?
                             `RWT_TMO_DEFAULT_S :
                             state_reg.blk[`RWT_OFF_TMO];
        state_next.idx = 9'h000;
        if (err != 16'h0000) begin
          state_next.err_code = err;
          state_next.st = S_ERRW;
        end else begin
          state_next.st = S_TXHDR;
        end
      end
      // ten header words: code, target, then the address fields
      S_TXHDR: begin
        if (!state_reg.tx_valid) begin
          state_next.tx_valid = 1'b1;
          state_next.tx_last = !state_reg.xchg &&
                               state_reg.idx == `RWT_HDR_LAST;
          unique case (state_reg.idx[3:0])
            4'h0: state_next.tx_data = state_reg.blk[`RWT_OFF_CODE];
            4'h1: state_next.tx_data = state_reg.ip[31:16];
            4'h2: state_next.tx_data = state_reg.ip[15:0];
            4'h3: state_next.tx_data = state_reg.port;
            4'h4: state_next.tx_data = state_reg.blk[`RWT_OFF_SRC];
            4'h5: state_next.tx_data = state_reg.blk[`RWT_OFF_CNT];
            4'h6: state_next.tx_data = state_reg.blk[`RWT_OFF_DST];
            4'h7: state_next.tx_data = state_reg.blk[`RWT_OFF_RSRC];
            4'h8: state_next.tx_data = state_reg.blk[`RWT_OFF_RCNT];
            default: state_next.tx_data = state_reg.blk[`RWT_OFF_RDST];
          endcase
        end else if (tx_ready) begin
          state_next.tx_valid = 1'b0;
          state_next.tx_last = 1'b0;
          if (state_reg.idx == `RWT_HDR_LAST) begin
            state_next.idx = 9'h000;
            state_next.tick = 24'h000000;
            state_next.st = state_reg.xchg ? S_TXRD : S_RX;
          end else begin
            state_next.idx = 9'(state_reg.idx + 9'h001);
          end
        end
      end
      // exchange: fetch one local write word
      S_TXRD: begin
        if (!state_reg.mem_req) begin
          state_next.mem_req = 1'b1;
          state_next.mem_we = 1'b0;
          state_next.mem_addr = waddr(state_reg.blk[`RWT_OFF_SRC],
                                      state_reg.idx);
        end else if (mem_ack) begin
          state_next.mem_req = 1'b0;
          state_next.tx_valid = 1'b1;
          state_next.tx_data = mem_rdata;
          state_next.tx_last = {7'h00, state_reg.idx} ==
                               16'(state_reg.blk[`RWT_OFF_CNT] - 16'h0001);
          state_next.st = S_TXDAT;
        end
      end
      // exchange: hand the word to the link
      S_TXDAT: begin
        if (tx_ready) begin
          state_next.tx_valid = 1'b0;
          state_next.tx_last = 1'b0;
          if (state_reg.tx_last) begin
            state_next.idx = 9'h000;
            state_next.tick = 24'h000000;
            state_next.st = S_RX;
          end else begin
            state_next.idx = 9'(state_reg.idx + 9'h001);
            state_next.st = S_TXRD;
          end
        end
      end
      // reply: status word then data; a word beats the timeout
      S_RX: begin
        if (rx_valid) begin
          if (state_reg.idx == 9'h000) begin
            state_next.rx_status = rx_data;
          end
          if (state_reg.idx != 9'h1ff) begin
            state_next.idx = 9'(state_reg.idx + 9'h001);
          end
          if (rx_last) begin
            if (stat == `RWT_RSP_WFAIL) begin
              err = `RWT_ERR_WRITE;
            end else if (stat == `RWT_RSP_RFAIL) begin
              err = `RWT_ERR_READ;
            end else if (stat != `RWT_RSP_OK ||
                         {7'h00, state_reg.idx} != rd_cnt) begin
              err = `RWT_ERR_RESP;
            end
            state_next.idx = 9'h000;
            if (err != 16'h0000) begin
              state_next.err_code = err;
              state_next.st = S_ERRW;
            end else begin
              state_next.st = S_WB;
            end
          end
        end else if (!state_reg.tmo_inf) begin
          if (state_reg.tick == 24'(CYC_PER_SEC - 1)) begin
            state_next.tick = 24'h000000;
            if (state_reg.tmo_sec <= 16'h0001) begin
              state_next.idx = 9'h000;
              state_next.err_code = `RWT_ERR_TIMEOUT;
              state_next.st = S_ERRW;
            end else begin
              state_next.tmo_sec = 16'(state_reg.tmo_sec - 16'h0001);
            end
          end else begin
            state_next.tick = 24'(state_reg.tick + 24'h000001);
          end
        end
      end
      // copy verified reply words into local memory
      S_WB: begin
        if (!state_reg.mem_req) begin
          state_next.mem_req = 1'b1;
          state_next.mem_we = 1'b1;
          state_next.mem_wdata = rxbuf_q;
          state_next.mem_addr = waddr(state_reg.xchg ?
                                      state_reg.blk[`RWT_OFF_RDST] :
                                      state_reg.blk[`RWT_OFF_DST],
                                      state_reg.idx);
        end else if (mem_ack) begin
          state_next.mem_req = 1'b0;
          state_next.mem_we = 1'b0;
          if ({7'h00, state_reg.idx} == 16'(rd_cnt - 16'h0001)) begin
            state_next.st = S_FIN;
          end else begin
            state_next.idx = 9'(state_reg.idx + 9'h001);
          end
        end
      end
      // error code into word 0 of the block, then raise the flag
      S_ERRW: begin
        if (!state_reg.mem_req) begin
          state_next.mem_req = 1'b1;
          state_next.mem_we = 1'b1;
          state_next.mem_addr = state_reg.base;
          state_next.mem_wdata = state_reg.err_code;
        end else if (mem_ack) begin
          state_next.mem_req = 1'b0;
          state_next.mem_we = 1'b0;
          state_next.err_flag = 1'b1;
          state_next.st = S_FIN;
        end
      end
      S_FIN: begin
        state_next.busy = 1'b0;
        state_next.done = 1'b1;
        state_next.st = S_IDLE;
      end
      default: begin
        state_next.st = S_IDLE;
      end
    endcase
  end

  // state register
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  // reply buffer, no reset needed: read only after a full reply
  always_ff @(posedge sys_clk) begin
    if (state_reg.st == S_RX && rx_valid && state_reg.idx != 9'h000 &&
        state_reg.idx <= 9'h100) begin
      rxbuf[8'(state_reg.idx - 9'h001)] <= rx_data;
    end
  end

  assign wb_dat_o = state_reg.wb_dat;
  assign wb_ack_o = state_reg.wb_ack;
  assign mem_req = state_reg.mem_req;
  assign mem_we = state_reg.mem_we;
  assign mem_addr = state_reg.mem_addr;
  assign mem_wdata = state_reg.mem_wdata;
  assign tx_valid = state_reg.tx_valid;
  assign tx_data = state_reg.tx_data;
  assign tx_last = state_reg.tx_last;
  assign busy = state_reg.busy;
  assign cmd_error_flag = state_reg.err_flag;

endmodule

// [dv/rwt_engine_asserts.sv]
// port assertions for the remote word transfer engine
`timescale 1ns/1ps
module rwt_engine_asserts (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic wb_ack_o,
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [15:0] mem_addr,
  input wire logic [15:0] mem_wdata,
  input wire logic mem_ack,
  input wire logic tx_valid,
  input wire logic [15:0] tx_data,
  input wire logic tx_last,
  input wire logic tx_ready,
  input wire logic busy,
  input wire logic cmd_error_flag
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  // bus answer timing
  a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("bus ack held longer than one cycle");
  a_ack_next_edge: assert property (
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("bus request not acked on the next edge");
  // memory request held until taken, then one idle cycle
  a_mem_hold: assert property (
    mem_req && !mem_ack |=> mem_req && $stable(mem_addr)
      && $stable(mem_we) && $stable(mem_wdata))
    else $error("memory request changed before it was taken");
  a_mem_gap: assert property (mem_req && mem_ack |=> !mem_req)
    else $error("memory request not dropped after transfer");
  // outgoing message words
  a_tx_hold: assert property (
    tx_valid && !tx_ready |=> tx_valid && $stable(tx_data)
      && $stable(tx_last))
    else $error("message word changed before it was taken");
  a_tx_gap: assert property (tx_valid && tx_ready |=> !tx_valid)
    else $error("message word offered twice in a row");
  a_tx_busy: assert property (tx_valid |-> busy)
    else $error("message sent with no command running");
  // sticky error flag only falls on a status write
  a_flag_sticky: assert property (
    $fell(cmd_error_flag) |-> $past(wb_cyc_i) && $past(wb_stb_i)
      && $past(wb_we_i) && $past(wb_adr_i) == 8'h04
      && ($past(wb_dat_i) & 32'h0000_0002) != 32'h0000_0000)
    else $error("error flag fell without a clearing write");
endmodule

bind rwt_engine rwt_engine_asserts u_chk (.sys_clk(sys_clk),
  .rst_b(rst_b), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
  .wb_ack_o(wb_ack_o), .mem_req(mem_req), .mem_we(mem_we),
  .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack),
  .tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last),
  .tx_ready(tx_ready), .busy(busy), .cmd_error_flag(cmd_error_flag));

// [dv/rwt_peer.sv]
// behavioural remote peer answering transfer messages
`timescale 1ns/1ps
module rwt_peer (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic tx_valid,
  input wire logic [15:0] tx_data,
  input wire logic tx_last,
  input wire logic [1:0] mode,
  input wire logic slow,
  output logic tx_ready,
  output logic rx_valid,
  output logic [15:0] rx_data,
  output logic rx_last
);
  logic [15:0] hdr [0:299];
  logic [15:0] src;
  int n = 0;
  int msgs = 0;
  int ph = -9;
  int cnt;
  // collect a message, pause two cycles, then answer a word per cycle
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      n = 0;
      ph = -9;
      tx_ready <= 1'b0;
      rx_valid <= 1'b0;
      rx_last <= 1'b0;
      rx_data <= 16'h0;
    end else begin
      tx_ready <= slow ? !tx_ready : 1'b1;
      rx_valid <= 1'b0;
      rx_last <= 1'b0;
      rx_data <= ~rx_data; // idle line never repeats its last word
      if (ph > -9 && ph < 0) ph++;
      else if (ph >= 0) begin
        rx_valid <= 1'b1;
        // write failure stops before any read
        rx_data <= (ph == 0) ? {14'h0, mode} : src + ph[15:0];
        rx_last <= ph == cnt || mode != 2'h0;
        ph = (ph == cnt || mode != 2'h0) ? -9 : ph + 1;
      end
      if (tx_valid && tx_ready) begin
        hdr[n] = tx_data;
        n++;
        if (tx_last) begin
          cnt = (hdr[0] == 16'h0203) ? hdr[8] : hdr[5];
          // remote word at one-based address a holds bfff+a
          src = 16'hbffe + ((hdr[0] == 16'h0203) ? hdr[7] : hdr[4]);
          ph = (mode == 2'h3) ? -9 : -2; // silent mode never answers
          n = 0;
          msgs++;
        end
      end
    end
  end
endmodule

// [dv/rwt_engine_bench.sv]
// self-checking bench for the remote word transfer engine
`timescale 1ns/1ps
module rwt_engine_bench;
  localparam logic [15:0] BASE = 16'h0010;
  logic sys_clk = 1'b0, rst_b = 1'b0, slow = 1'b0, mem_ack = 1'b0;
  logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h0;
  logic [3:0] wb_sel_i = 4'hf;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
  logic wb_ack_o, mem_req, mem_we, tx_valid, tx_last, tx_ready;
  logic rx_valid, rx_last, busy, cmd_error_flag;
  logic [15:0] mem_addr, mem_wdata, mem_rdata, tx_data, rx_data;
  logic [1:0] mode = 2'h0;
  logic [15:0] mem [0:1023];
  logic [15:0] blk [16];
  int miscompares = 0, cmp_count = 0, lat, ticks = 0;
  rwt_engine #(.CYC_PER_SEC(20)) DUT (.sys_clk, .rst_b, .wb_cyc_i,
    .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o,
    .wb_ack_o, .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_rdata,
    .mem_ack, .tx_valid, .tx_data, .tx_last, .tx_ready, .rx_valid,
    .rx_data, .rx_last, .busy, .cmd_error_flag);
  rwt_peer peer (.sys_clk, .rst_b, .tx_valid, .tx_data, .tx_last, .mode,
    .slow, .tx_ready, .rx_valid, .rx_data, .rx_last);
  initial forever #50 sys_clk = ~sys_clk;
  assign mem_rdata = mem[mem_addr[9:0]];
  // local memory answers one cycle after each request
  always @(posedge sys_clk) begin
    mem_ack <= mem_req && !mem_ack;
    if (mem_req && mem_ack && mem_we) mem[mem_addr[9:0]] <= mem_wdata;
  end
  // hang guard far above the longest run
  always @(posedge sys_clk) begin
    ticks++;
    if (ticks == 20000) begin
      miscompares++;
      give_verdict();
    end
  end
  task automatic give_verdict();
    if (miscompares == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic cmp(input string n, input logic [15:0] e, s);
    cmp_count++;
    if (s !== e) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask
  // one classic cycle; ack is the only edge that completes it
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d, output logic [31:0] r);
    @(posedge sys_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do @(posedge sys_clk); while (wb_ack_o !== 1'b1);
    r = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  // typical blocks; scenarios then patch one word, or both IP words
  function automatic void set_blk(input logic x);
    for (int i = 0; i < 16; i++) blk[i] = 16'h0;
    blk[1] = x ? 16'h0203 : 16'h0202;
    blk[2] = x ? 16'h4b16 : 16'h4b15;
    blk[3] = x ? 16'h0028 : 16'h0005;
    blk[4] = x ? 16'h0003 : 16'h0100;
    blk[5] = x ? 16'h0007 : 16'h012c;
    blk[7] = x ? 16'h0009 : 16'h0;
    blk[8] = x ? 16'h0004 : 16'h0;
    blk[9] = x ? 16'h003c : 16'h0;
    blk[10] = x ? 16'hc0a8 : 16'h0;
    blk[11] = x ? 16'hb101 : 16'h0;
    blk[12] = x ? 16'h05e1 : 16'h0;
  endfunction
  // load block, clear old flags, start; go also waits for the end
  task automatic start();
    logic [31:0] r;
    for (int i = 0; i < 16; i++) mem[BASE + i] = blk[i];
    wb(1'b1, 8'h04, 32'h6, r);
    wb(1'b1, 8'h00, {BASE, 16'h0001}, r);
    while (busy !== 1'b1) @(posedge sys_clk);
  endtask
  task automatic go();
    start();
    lat = 0;
    while (busy !== 1'b0) begin
      @(posedge sys_clk);
      lat++;
    end
  endtask
  task automatic chk_err(input logic [15:0] e);
    logic [31:0] r;
    wb(1'b0, 8'h04, 32'h0, r);
    cmp("error word", e, mem[BASE]);
    cmp("error flag", {15'h0, e != 16'h0}, {15'h0, cmd_error_flag});
    if (e != 16'h0) cmp("status code", e, r[31:16]);
  endtask
  task automatic chk_hdr(input logic [15:0] h, l, p);
    logic [15:0] e [10];
    e = '{blk[1], h, l, p, blk[3], blk[4], blk[5], blk[7], blk[8], blk[9]};
    for (int i = 0; i < 10; i++) cmp("header", e[i], peer.hdr[i]);
  endtask
  task automatic t_errors();
    bit xs [10] = '{0, 0, 1, 1, 1, 0, 0, 0, 1, 1};
    int wi [10] = '{4, 4, 4, 4, 8, 1, 2, 2, 10, 10};
    logic [15:0] wv [10] = '{16'h0, 16'h0101, 16'h0, 16'h00ff, 16'h0101,
      16'h0201, 16'h4b1d, 16'h4b17, 16'h0, 16'he000};
    logic [15:0] ec [10] = '{16'h3, 16'h3, 16'h3, 16'h3, 16'h3, 16'h1,
      16'h2, 16'h2, 16'h4, 16'h4};
    int m;
    for (int k = 0; k < 10; k++) begin
      set_blk(xs[k]);
      blk[wi[k]] = wv[k];
      if (wi[k] == 10) blk[11] = wv[k];
      m = peer.msgs;
      go();
      chk_err(ec[k]);
      cmp("messages", m[15:0], peer.msgs[15:0]);
    end
  endtask
  task automatic t_fetch();
    set_blk(1'b0);
    go();
    chk_err(16'h0);
    chk_hdr(16'h0a00, 16'h0001, 16'h1234);
    for (int i = 0; i < 256; i++)
      cmp("fetched", 16'hc004 + i[15:0], mem[299 + i]);
  endtask
  task automatic t_xchg();
    set_blk(1'b1);
    for (int i = 0; i < 3; i++) mem[39 + i] = 16'h5a00 + i[15:0];
    slow <= 1'b1;
    go();
    slow <= 1'b0;
    chk_err(16'h0);
    chk_hdr(16'hc0a8, 16'hb101, 16'h05e1);
    for (int i = 0; i < 3; i++)
      cmp("sent", 16'h5a00 + i[15:0], peer.hdr[10 + i]);
    for (int i = 0; i < 4; i++)
      cmp("read", 16'hc008 + i[15:0], mem[59 + i]);
  endtask
  task automatic t_fail();
    for (int k = 1; k < 3; k++) begin
      set_blk(1'b1);
      for (int i = 0; i < 4; i++) mem[59 + i] = 16'h0;
      mode <= k[1:0];
      go();
      chk_err(16'h6 + k[15:0]);
      for (int i = 0; i < 4; i++) cmp("kept", 16'h0, mem[59 + i]);
    end
  endtask
  // both waits share the same lead-in, so only the timeout differs
  task automatic t_timeout();
    int l1;
    mode <= 2'h3;
    for (int k = 1; k >= 0; k--) begin
      set_blk(1'b1);
      blk[6] = k[15:0];
      go();
      chk_err(16'h0005);
      cmp("kept", 16'h0, mem[59]);
      if (k == 1) l1 = lat;
    end
    cmp("wait", 16'h1, {15'h0, lat - l1 == 160 && l1 >= 20});
  endtask
  task automatic t_forever();
    set_blk(1'b1);
    blk[6] = 16'h03e7;
    start();
    repeat (400) @(posedge sys_clk);
    cmp("endless", 16'h1, {15'h0, busy});
    rst_b <= 1'b0;
    mode <= 2'h0;
    repeat (8) @(posedge sys_clk);
    rst_b <= 1'b1;
    @(posedge sys_clk);
    cmp("reset busy", 16'h0, {15'h0, busy});
    cmp("reset flag", 16'h0, {15'h0, cmd_error_flag});
  endtask
  initial begin
    logic [31:0] r;
    repeat (8) @(posedge sys_clk);
    rst_b <= 1'b1;
    wb(1'b1, 8'h40, 32'h12340003, r);
    wb(1'b1, 8'h44, 32'h0a000001, r);
    wb(1'b1, 8'h48, 32'h43210007, r);
    wb(1'b1, 8'h4c, 32'h0b000002, r);
    wb(1'b0, 8'h20, 32'h0, r);
    cmp("unmapped hi", 16'h0, r[31:16]);
    cmp("unmapped lo", 16'h0, r[15:0]);
    t_errors();
    t_fetch();
    t_xchg();
    t_fail();
    t_timeout();
    t_forever();
    give_verdict();
  end
endmodule
